/* hw/ar_fifo.v */
// Small flip-flop FIFO with valid/ready on both sides
`default_nettype none
module ar_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clock_i,   // System clock
	input  wire             rst_i,     // Async reset, active high
	input  wire             flush_i,   // Synchronous flush
	input  wire [WIDTH-1:0] in_data_i, // Write data
	input  wire             in_valid_i,// Write request
	output wire             in_ready_o,// Not full
	output wire [WIDTH-1:0] out_data_o,// Head word
	output wire             out_valid_o,// Not empty
	input  wire             out_ready_i // Reader takes head
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;
	integer         i;

	assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o  = mem_q[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;

	// Pointers wrap at DEPTH so non-power-of-two depths work
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= {WIDTH{1'b0}};
		end else if (flush_i) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_q[wr_q] <= in_data_i;
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // ar_fifo
`default_nettype wire

/* hw/ar_result_if.v */
// Conversion result readout interface: parallel and serial host port
// Summary of operation
// R1 - Outputs driven only while select and read low
// R2 - Reset rise aborts conversion, floats bus
// R3 - Reset fall clears state, bus, configuration
// R4 - Serial select low parallel, high serial
// R5 - Tied-low select and read drive continuously
// R6 - Host reads after, or early during, conversion
// R7 - Byte swap exchanges low and high bytes
// R8 - Serial sends sixteen bits, MSB first
// R9 - Serial bit stable across both clock edges; the shifter here changes the bit at the trailing clock edge
// R10 - Configuration port only in serial mode
// R11 - Internal clock: device drives clock, frame
// R12 - Invert inputs flip clock and frame strobe
// R13 - Master during conversion: two clock periods
// R14 - Master after conversion: busy until shifted
// R15 - Divider inputs set fixed serial period
// R16 - External clock accepted, gated by select
// R17 - Slave reads after or during conversion
// R18 - External clock may idle high or low
// R19 - Host clock quiet late in conversion
// R20 - Output coding offset binary or complement
// R21 - Serial functions placed on data lines
// R22 - Start falling edge alone begins conversion
// R23 - Unfinished slave read pulses overrun flag
// R24 - Busy until latched; result loads then
`default_nettype none
`include "ar_result_if_regs.vh"
module ar_result_if #(
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW    = 2
) (
	input  wire        clock_i,           // 10 MHz system clock
	input  wire        rst_i,             // Async reset, active high
	input  wire        adc_reset_i,       // Device reset pin
	input  wire        conversion_start_n_i, // Start strobe, active low
	input  wire        power_down_input_i,// Power down pin
	input  wire        cs_n_i,            // Chip select, active low
	input  wire        rd_n_i,            // Read enable, active low
	input  wire        serial_select_i,   // High selects serial port
	input  wire        output_coding_select_i, // High straight binary
	input  wire        byte_order_swap_i, // Swap result bytes
	input  wire        external_clock_select_i, // High slave clock
	input  wire        serial_clock_invert_i,   // Invert clock
	input  wire        frame_strobe_invert_i,   // Invert frame strobe
	input  wire        read_during_conversion_i,// Read during conv
	input  wire [1:0]  serial_clock_divider_i,  // Master clock rate
	input  wire [15:0] sar_result_i,      // Core result, binary
	input  wire [15:0] data_i,            // Data bus pin levels
	output reg  [15:0] data_o,            // Data bus drive value
	output reg  [15:0] data_oe_o,         // Data bus drive enables
	output reg         busy_o,            // Conversion busy
	output reg         powered_down_o     // Power down state
);
	// -----------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------
	localparam NS = 20;
	wire [NS-1:0] pin_raw = {adc_reset_i, conversion_start_n_i,
		power_down_input_i, cs_n_i, rd_n_i, serial_select_i,
		output_coding_select_i, byte_order_swap_i,
		external_clock_select_i, serial_clock_invert_i,
		frame_strobe_invert_i, read_during_conversion_i,
		serial_clock_divider_i, data_i[15:12],
		data_i[`AR_S_SCK_BIT], data_i[`AR_S_CHAIN_BIT]};
	reg  [NS-1:0] meta_q;
	reg  [NS-1:0] pin_q;
	// Two stages; only pin_q is read by logic. Active-low pins reset
	// to idle high, else the strobe edge detector sees a false start
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= `AR_PIN_IDLE;
			pin_q  <= `AR_PIN_IDLE;
		end else begin
			meta_q <= pin_raw;
			pin_q  <= meta_q;
		end
	end
	wire       rpin   = pin_q[19];
	wire       cnv_n  = pin_q[18];
	wire       pd     = pin_q[17];
	wire       cs_n   = pin_q[16];
	wire       rd_n   = pin_q[15];
	wire       ser    = pin_q[14];
	wire       ob     = pin_q[13];
	wire       swap   = pin_q[12];
	wire       ext    = pin_q[11];
	wire       inv_ck = pin_q[10];
	wire       inv_fs = pin_q[9];
	wire       read_during_conversion    = pin_q[8];
	wire [1:0] div    = pin_q[7:6];
	wire [3:0] cfg_in = pin_q[5:2];
	wire       sck_in = pin_q[1];
	wire       chain  = pin_q[0];

	// -----------------------------------------------------------
	// Edges and mode decode
	// -----------------------------------------------------------
	reg  rpin_d_q;
	reg  cnv_d_q;
	reg  sck_d_q;
	wire rst_rise = rpin & ~rpin_d_q;
	wire rst_fall = ~rpin & rpin_d_q;
	wire start    = ~cnv_n & cnv_d_q & ~rpin;
	wire master   = ser & ~ext;                        // R11
	wire slave    = ser & ext;                         // R16
	wire read_en  = ~cs_n & ~rd_n & ~rpin;             // R1
	// Gate the host clock with select; edge polarity follows invert
	wire sck_g    = sck_in & ~cs_n;                    // R16
	wire sck_act  = slave & ~cs_n & (sck_g != sck_d_q)
		& (sck_g == inv_ck);                           // R18

	// Coding: core gives offset binary, complement flips the MSB
	function [15:0] code;
		input [15:0] raw;
		input        straight;
		begin
			code = {raw[15] ^ ~straight, raw[14:0]};   // R20
		end
	endfunction

	// -----------------------------------------------------------
	// Conversion sequencer
	// -----------------------------------------------------------
	localparam S_IDLE = 2'h0;
	localparam S_CONV = 2'h1;
	localparam S_SEND = 2'h2;
	localparam integer CONV_CYC_I = `AR_CONV_CYC;
	localparam [7:0]   CONV_CYC   = CONV_CYC_I[7:0];
	reg  [1:0]  st_q;
	reg  [7:0]  cc_q;
	reg  [15:0] out_q;
	reg  [8:0]  cfg_q;
	reg  [15:0] sh_q;
	reg  [4:0]  bits_q;
	reg  [3:0]  hc_q;
	reg         sck_q;
	reg         pend_q;
	reg         err_q;
	wire        f_ready;
	wire        f_valid;
	wire [15:0] f_data;
	wire        conv_end = (st_q == S_CONV) && (cc_q == 8'h01);
	// Results wait in the FIFO; while full, new starts are refused
	wire        f_push   = conv_end;
	wire        f_pop    = f_valid & (bits_q == 5'h00);

	ar_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.flush_i     (rst_fall),
		.in_data_i   (code(sar_result_i, ob)),
		.in_valid_i  (f_push),
		.in_ready_o  (f_ready),
		.out_data_o  (f_data),
		.out_valid_o (f_valid),
		.out_ready_i (f_pop)
	);

	// Start only on the strobe edge; power down cannot abort it
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_q     <= S_IDLE;
			cc_q     <= 8'h00;
			rpin_d_q <= 1'b0;
			cnv_d_q  <= 1'b1;
			sck_d_q  <= 1'b0;
			busy_o   <= 1'b0;
			powered_down_o <= 1'b0;
		end else begin
			rpin_d_q <= rpin;
			cnv_d_q  <= cnv_n;
			sck_d_q  <= sck_g;
			if (st_q != S_CONV)
				powered_down_o <= pd;
			case (st_q)
			S_IDLE: begin
				if (start & f_ready & ~pd) begin  // R22
					st_q <= S_CONV;
					cc_q <= CONV_CYC;
					busy_o <= 1'b1;                // R24
				end
			end
			S_CONV: begin
				cc_q <= cc_q - 8'h01;
				if (conv_end) begin
					// Master after-conversion keeps busy for shifting
					if (master & ~read_during_conversion) begin
						st_q <= S_SEND;            // R14
					end else begin
						st_q <= S_IDLE;
						busy_o <= 1'b0;            // R24
					end
				end
			end
			S_SEND: begin
				if (~f_valid && bits_q == 5'h00) begin
					st_q <= S_IDLE;
					busy_o <= 1'b0;                // R14
				end
			end
			default: st_q <= S_IDLE;
			endcase
			if (rst_rise) begin
				st_q   <= S_IDLE;                  // R2
				busy_o <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------
	// Result register, configuration and serial shifter
	// -----------------------------------------------------------
	wire [3:0] half = (master & read_during_conversion) ?
		((bits_q > `AR_SLOW_BITS) ? `AR_FAST_HALF : `AR_SLOW_HALF)
		: (4'h1 << div);                           // R13 R15
	wire load_m = master & ~read_during_conversion & f_pop;           // R14
	wire load_r = master & read_during_conversion & start & f_ready & (st_q == S_IDLE);
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			out_q  <= `AR_RESULT_RST;
			cfg_q  <= `AR_CFG_RST;
			sh_q   <= 16'h0000;
			bits_q <= 5'h00;
			hc_q   <= 4'h0;
			sck_q  <= 1'b0;
			pend_q <= 1'b0;
			err_q  <= 1'b0;
		end else if (rst_fall) begin
			out_q  <= `AR_RESULT_RST;              // R3
			cfg_q  <= `AR_CFG_RST;
			sh_q   <= 16'h0000;
			bits_q <= 5'h00;
			sck_q  <= 1'b0;
			pend_q <= 1'b0;
			err_q  <= 1'b0;
		end else begin
			err_q <= 1'b0;
			if (f_pop)
				out_q <= f_data;                   // R24
			// Configuration nibble sampled only in serial mode
			if (ser & ~rpin)
				cfg_q <= {cfg_q[4:0], cfg_in};     // R10
			if (load_m | load_r) begin
				sh_q   <= load_m ? f_data : out_q; // R8 R13
				bits_q <= `AR_WORD_BITS;
				hc_q   <= 4'h0;
				sck_q  <= 1'b0;
			end else if (master && bits_q != 5'h00) begin
				if (hc_q == half - 4'h1) begin
					hc_q  <= 4'h0;
					sck_q <= ~sck_q;               // R11
					// Data moves only at the falling edge, after the high half
					if (sck_q) begin
						sh_q   <= {sh_q[14:0], 1'b0}; // R9
						bits_q <= bits_q - 5'h01;
					end
				end else begin
					hc_q <= hc_q + 4'h1;
				end
			end else if (slave) begin
				if (f_pop) begin
					sh_q   <= f_data;              // R17
					bits_q <= `AR_WORD_BITS;
				end else if (sck_act && read_en && bits_q != 5'h00) begin
					sh_q   <= {sh_q[14:0], chain}; // R8
					bits_q <= bits_q - 5'h01;
				end
			end
			// Slave read-during: overrun if word unfinished at end
			if (slave & read_during_conversion & start & (bits_q != 5'h00))
				pend_q <= 1'b1;
			if (conv_end) begin
				pend_q <= 1'b0;
				err_q  <= pend_q & (bits_q != 5'h00); // R23
			end
		end
	end

	// -----------------------------------------------------------
	// Pin drive
	// -----------------------------------------------------------
	reg [15:0] d_d;
	reg [15:0] oe_d;
	always @* begin
		d_d  = 16'h0000;
		oe_d = 16'h0000;
		if (~ser) begin
			d_d  = swap ? {out_q[7:0], out_q[15:8]} : out_q; // R4 R7
			oe_d = {16{read_en}};                  // R1 R5
		end else if (master) begin
			d_d[`AR_M_SDO_BIT]  = sh_q[15];        // R21
			d_d[`AR_M_SCK_BIT]  = sck_q ^ inv_ck;  // R12
			d_d[`AR_M_SYNC_BIT] = (bits_q != 5'h00) ^ inv_fs; // R12
			oe_d[`AR_M_SYNC_BIT:`AR_M_SDO_BIT] = {3{read_en}};
		end else begin
			d_d[`AR_S_SDO_BIT] = sh_q[15];         // R21
			d_d[`AR_S_ERR_BIT] = err_q;
			oe_d[`AR_S_SDO_BIT] = read_en;
			oe_d[`AR_S_ERR_BIT] = read_en;
		end
	end
	// Registered so pins never glitch off decode
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			data_o    <= 16'h0000;
			data_oe_o <= 16'h0000;
		end else begin
			data_o    <= d_d;
			data_oe_o <= rpin ? 16'h0000 : oe_d;   // R2
		end
	end
endmodule // ar_result_if
`default_nettype wire

/* hw/ar_result_if_regs.vh */
// Constants for the conversion result readout interface
`ifndef AR_RESULT_IF_REGS_VH
`define AR_RESULT_IF_REGS_VH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define AR_CLK_NS        100
`define AR_CONV_NS       1500
`define AR_CONV_CYC      ((`AR_CONV_NS + `AR_CLK_NS - 1) / `AR_CLK_NS)
`define AR_FAST_HALF     4'h1
`define AR_SLOW_HALF     4'h3
`define AR_SLOW_BITS     5'h04
`define AR_WORD_BITS     5'h10
// ---------------------------------------------------------------
// Serial pin positions on the shared data bus
// ---------------------------------------------------------------
`define AR_M_SDO_BIT     2
`define AR_M_SCK_BIT     3
`define AR_M_SYNC_BIT    4
`define AR_S_SDO_BIT     5
`define AR_S_SCK_BIT     6
`define AR_S_ERR_BIT     7
`define AR_S_CHAIN_BIT   8
`define AR_CFG_LO_BIT    12
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define AR_RESULT_RST    16'h0000
`define AR_CFG_RST       9'h000
// Synchroniser reset: start strobe, select and read sit at idle high
`define AR_PIN_IDLE      20'h58000
`endif

/* sim/ar_host_model.sv */
// Host model reading one serial word on its own clock
`default_nettype none
module ar_host_model #(
	parameter int HALF = 6 // Cycles per clock half
) (
	input wire logic         clock_i, // Clock
	input wire logic         go_i,    // Start a frame
	input wire logic         idle_i,  // Clock level between frames
	input wire logic         sdo_i,   // Serial data from device
	output var logic         sclk_o,  // Serial clock to device
	output var logic [15:0]  word_o,  // Word read
	output var logic         done_o   // Frame finished
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clock stands at its idle level outside frames
	initial begin
		sclk_o = 1'b0;
		word_o = 16'h0000;
		done_o = 1'b0;
		forever begin
			@(posedge clock_i);
			sclk_o <= idle_i;
			if (go_i) begin
				done_o <= 1'b0;
				repeat (16) begin
					repeat (HALF) @(posedge clock_i);
					word_o <= {word_o[14:0], sdo_i};
					sclk_o <= ~idle_i;
					repeat (HALF) @(posedge clock_i);
					sclk_o <= idle_i;
				end
				repeat (HALF) @(posedge clock_i);
				done_o <= 1'b1;
			end
		end
	end
endmodule // ar_host_model
`default_nettype wire

/* sim/ar_result_if_monitor.sv */
// Concurrent checks on the result readout port
`default_nettype none
module ar_result_if_monitor (
	input wire logic        clock_i,   // Clock
	input wire logic        rst_i,     // Reset
	input wire logic        adc_reset_i, // Device reset
	input wire logic        cs_n_i,    // Select
	input wire logic        rd_n_i,    // Read
	input wire logic        serial_select_i, // Serial
	input wire logic        external_clock_select_i, // Slave
	input wire logic [15:0] data_o,    // Bus values
	input wire logic [15:0] data_oe_o, // Bus enables
	input wire logic        busy_o     // Busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Six cycles of a level covers the pin synchronisers
	wire ok = !cs_n_i && !rd_n_i && !adc_reset_i;
	wire par = ok && !serial_select_i;
	wire sr = ok && serial_select_i;
	wire mst = sr && !external_clock_select_i;
	wire slv = sr && external_clock_select_i;
	property p_float;
		(cs_n_i || rd_n_i) [*6] |-> data_oe_o == 16'h0000;
	endproperty
	a_float: assert property (p_float)
		else $error("bus driven while deselected");
	property p_rst;
		adc_reset_i [*6] |-> !busy_o && data_oe_o == 16'h0000;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset did not abort and float");
	property p_par;
		par [*6] |-> data_oe_o == 16'hffff;
	endproperty
	a_par: assert property (p_par)
		else $error("parallel bus not driven");
	property p_cfg;
		serial_select_i [*6] |-> data_oe_o[15:12] == 4'h0;
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("configuration pins driven");
	property p_mst;
		mst [*6] |-> data_oe_o[4:2] == 3'h7;
	endproperty
	a_mst: assert property (p_mst)
		else $error("master pins not driven");
	property p_slv;
		slv [*6] |-> data_oe_o[6:5] == 2'h1;
	endproperty
	a_slv: assert property (p_slv)
		else $error("slave pin directions wrong");
	// A reset in mid-conversion legally cuts the busy window short
	property p_conv;
		disable iff (rst_i || adc_reset_i)
		$rose(busy_o) |=> busy_o [*8];
	endproperty
	a_conv: assert property (p_conv)
		else $error("busy window too short");
	property p_ovr;
		(slv [*6] ##0 $rose(data_o[7])) |=> !data_o[7];
	endproperty
	a_ovr: assert property (p_ovr)
		else $error("overrun flag longer than a pulse");
	c_conv: cover property ($fell(busy_o));
	c_mst: cover property (mst && $rose(data_o[3]));
	c_slv: cover property (slv && $fell(busy_o));
	c_ovr: cover property (slv && $rose(data_o[7]));
endmodule // ar_result_if_monitor
bind ar_result_if ar_result_if_monitor u_mon (.clock_i(clock_i),
	.rst_i(rst_i), .adc_reset_i(adc_reset_i), .cs_n_i(cs_n_i),
	.rd_n_i(rd_n_i), .serial_select_i(serial_select_i),
	.external_clock_select_i(external_clock_select_i),
	.data_o(data_o), .data_oe_o(data_oe_o), .busy_o(busy_o));
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the result readout port
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i, rst_i, rst_q, sn_q, pd_q, cs_q, rd_q, ser_q, cod_q;
	logic swp_q, ext_q, si_q, fi_q, rdc_q, ch_q, go_q, sclk, hdone;
	logic busy_o, pd_o, sck_d = 1'b0;
	logic [1:0] div_q;
	logic [15:0] sar_q, data_o, oe, hword, w, cap, bus_in;
	logic [31:0] seed;
	int mismatches, checks_done, cycles, n, nb, fb, n0, f0, ovr;
	assign bus_in = {7'h00, ch_q, 1'b0, sclk, 6'h00};
	ar_result_if dut (.clock_i(clock_i), .rst_i(rst_i),
		.adc_reset_i(rst_q), .conversion_start_n_i(sn_q),
		.power_down_input_i(pd_q), .cs_n_i(cs_q), .rd_n_i(rd_q),
		.serial_select_i(ser_q), .output_coding_select_i(cod_q),
		.byte_order_swap_i(swp_q), .external_clock_select_i(ext_q),
		.serial_clock_invert_i(si_q), .frame_strobe_invert_i(fi_q),
		.read_during_conversion_i(rdc_q), .serial_clock_divider_i(div_q),
		.sar_result_i(sar_q), .data_i(bus_in), .data_o(data_o),
		.data_oe_o(oe), .busy_o(busy_o), .powered_down_o(pd_o));
	ar_host_model host (.clock_i(clock_i), .go_i(go_q), .idle_i(si_q),
		.sdo_i(data_o[5]), .sclk_o(sclk), .word_o(hword), .done_o(hdone));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Two's complement is the offset code with its top bit flipped
	function automatic logic [15:0] cd(input logic [15:0] r);
		return cod_q ? r : {~r[15], r[14:0]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
	endtask
	task automatic wait_busy(input logic lvl);
		n = 0;
		while (busy_o !== lvl && n < 900) begin
			cyc(1);
			n++;
		end
		chk({15'h0, busy_o}, {15'h0, lvl});
	endtask
	task automatic convert;
		sn_q <= 1'b0;
		wait_busy(1'b1);
		sn_q <= 1'b1;
		wait_busy(1'b0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	// Master word taken at each leading edge; frame must stand meanwhile
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop;
		end
		sck_d <= data_o[3] ^ si_q;
		// Overrun pulses seen on the slave error pin
		if (ser_q && ext_q && oe[7] && data_o[7])
			ovr <= ovr + 1;
		if ((data_o[3] ^ si_q) && !sck_d && ser_q && !ext_q) begin
			cap <= {cap[14:0], data_o[2]};
			nb <= nb + 1;
			fb <= fb + int'(!(data_o[4] ^ fi_q));
		end
	end
	initial begin
		{rst_q, pd_q, cs_q, rd_q, ser_q, cod_q, swp_q, ext_q} = 8'h00;
		{si_q, fi_q, rdc_q, ch_q, go_q, div_q} = 7'h00;
		{sn_q, rst_i, sar_q, seed} = {2'h3, 16'h0000, 32'h8368};
		{mismatches, checks_done, cycles, nb, fb, ovr} = '0;
		cyc(4);
		rst_i <= 1'b0;
		cyc(2);
		// Both codings and byte orders; all-zero and all-one first
		for (int m = 0; m < 8; m++) begin
			seed = xs(seed);
			sar_q <= (m < 2) ? {16{m[0]}} : seed[15:0];
			{swp_q, cod_q} <= m[1:0];
			convert;
			cyc(6);
			w = cd(sar_q);
			chk(data_o, swp_q ? {w[7:0], w[15:8]} : w);
			chk(oe, 16'hffff);
		end
		for (int k = 1; k < 3; k++) begin
			{cs_q, rd_q} <= k[1:0];
			cyc(6);
			chk(oe, 16'h0000);
		end
		// Power down neither aborts a running conversion nor starts one
		sn_q <= 1'b0;
		wait_busy(1'b1);
		{sn_q, pd_q} <= 2'h3;
		cyc(5);
		chk({14'h0, busy_o, pd_o}, 16'h0002);
		wait_busy(1'b0);
		cyc(2);
		chk({15'h0, pd_o}, 16'h0001);
		sn_q <= 1'b0;
		cyc(8);
		chk({15'h0, busy_o}, 16'h0000);
		{sn_q, pd_q} <= 2'h2;
		cyc(6);
		chk({15'h0, pd_o}, 16'h0000);
		{cs_q, rd_q} <= 2'h0;
		sn_q <= 1'b0;
		wait_busy(1'b1);
		{rst_q, sn_q} <= 2'h3;
		cyc(8);
		chk(oe, 16'h0000);
		chk({15'h0, busy_o}, 16'h0000);
		rst_q <= 1'b0;
		cyc(8);
		chk(data_o, 16'h0000);
		$display("parallel and reset tests done");
		ser_q <= 1'b1;
		for (int d = 0; d < 4; d++) begin
			seed = xs(seed);
			{si_q, fi_q, div_q, sar_q} <= {seed[17:16], d[1:0], seed[15:0]};
			cyc(8);
			{n0, f0} = {nb, fb};
			convert;
			chk(16'(nb - n0), 16'h0010);
			chk(cap, cd(sar_q));
			chk(16'(fb - f0), 16'h0000);
		end
		// Read during conversion sends the previous word, two periods
		w = cd(sar_q);
		{rdc_q, sar_q} <= {1'b1, ~sar_q};
		cyc(8);
		{n0, f0} = {nb, fb};
		convert;
		cyc(60);
		chk(16'(nb - n0), 16'h0010);
		chk(cap, w);
		chk(16'(fb - f0), 16'h0000);
		rdc_q <= 1'b0;
		$display("master serial test done");
		ext_q <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			seed = xs(seed);
			{si_q, ch_q, sar_q} <= {k[0], seed[16:0]};
			cyc(8);
			convert;
			go_q <= 1'b1;
			cyc(2);
			go_q <= 1'b0;
			n = 0;
			while (hdone !== 1'b1 && n < 400) begin
				cyc(1);
				n++;
			end
			chk(hword, cd(sar_q));
		end
		// Word left unread across the next conversion flags overrun
		rdc_q <= 1'b1;
		cyc(8);
		convert;
		convert;
		cyc(4);
		chk(16'(ovr), 16'h0001);
		$display("slave serial test done");
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
